//--- design/hscc_pkg.sv
package hscc_pkg;

	// ==========================================================
	// register bus geometry
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;

	// ==========================================================
	// register offsets
	localparam logic [2:0] OFS_OSC_MODE = 3'h0;
	localparam logic [2:0] OFS_HS_OSC = 3'h1;
	localparam logic [2:0] OFS_MAIN_MODE = 3'h2;
	localparam logic [2:0] OFS_PROC_CLK = 3'h3;
	localparam logic [2:0] OFS_INT_OSC = 3'h4;

	// ==========================================================
	// field positions
	localparam int unsigned BIT_EXT_SEL = 7;
	localparam int unsigned BIT_PIN_MODE = 6;
	localparam int unsigned BIT_GAIN = 0;
	localparam int unsigned BIT_HS_HALT = 7;
	localparam int unsigned BIT_SRC_SEL = 2;
	localparam int unsigned BIT_MAIN_STAT = 1;
	localparam int unsigned BIT_MUX = 0;
	localparam int unsigned BIT_SUB_STAT = 5;
	localparam int unsigned BIT_CPU_SRC = 4;
	localparam int unsigned BIT_INT_STABLE = 7;
	localparam int unsigned BIT_INT_HALT = 0;

	// ==========================================================
	// values after reset, and the largest accepted divider code
	localparam logic RST_HS_HALT = 1'b1;
	localparam logic [2:0] RST_DIV_CODE = 3'h1;
	localparam logic [2:0] DIV_CODE_MAX = 3'h4;

	// ==========================================================
	// timing
	localparam int unsigned SYS_CLK_PERIOD_NS = 20;
	localparam int unsigned GAIN_HOLD_NS = 5000;
	// least time: round up to whole cycles
	localparam int unsigned GAIN_HOLD_CYC =
		(GAIN_HOLD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam logic [7:0] GAIN_HOLD_LOAD = 8'(GAIN_HOLD_CYC);
	// internal oscillator edges counted before it is called settled
	localparam logic [7:0] INT_SETTLE_EDGES = 8'h20;

	// ==========================================================
	// source clock sampler slots
	localparam int unsigned SRC_N = 4;
	localparam int unsigned SRC_INT = 0;
	localparam int unsigned SRC_HS = 1;
	localparam int unsigned SRC_SUB = 2;
	localparam int unsigned SRC_LOW = 3;

endpackage : hscc_pkg

//--- design/hscc_glitchfree_mux.sv
`timescale 1ns/1ps
module hscc_glitchfree_mux
	import hscc_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic i_pulse_a,
	input wire logic i_pulse_b,
	input wire logic i_sel_b,
	output logic o_pulse,
	output logic o_sel_b
);

	// ==========================================================
	// state
	typedef struct packed {
		logic cur_b;
		logic gap;
		logic pulse;
	} hscc_mux_state_t;

	hscc_mux_state_t state;
	hscc_mux_state_t next_state;
	logic old_pulse;
	logic new_pulse;

	// pulses of the source in use and of the other one
	assign old_pulse = state.cur_b ? i_pulse_b : i_pulse_a;
	assign new_pulse = state.cur_b ? i_pulse_a : i_pulse_b;

	// hand over only on period boundaries of both sources
	always_comb begin
		next_state = state;
		next_state.pulse = 1'b0;
		if (!state.gap) begin
			if (i_sel_b != state.cur_b) begin
				// old period ends here; its next one is dropped
				if (old_pulse) begin
					next_state.gap = 1'b1;
				end
			end else begin
				next_state.pulse = old_pulse;
			end
		end else if (new_pulse) begin
			// first full period of the new source
			next_state.gap = 1'b0;
			next_state.cur_b = ~state.cur_b;
			next_state.pulse = 1'b1;
		end
	end

	// register the state
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign o_pulse = state.pulse;
	assign o_sel_b = state.cur_b;

endmodule : hscc_glitchfree_mux

//--- design/hscc_clock_ctrl.sv
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module hscc_clock_ctrl
	import hscc_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	input wire logic i_int_osc_clk,
	input wire logic i_hs_clk,
	input wire logic i_sub_clk,
	input wire logic i_low_osc_clk,
	input wire logic i_stop_exec,
	input wire logic i_stop_release,
	output logic o_gain_high,
	output logic o_x1_osc_mode,
	output logic o_x2_clk_mode,
	output logic o_hs_osc_run,
	output logic o_ext_clk_in_en,
	output logic o_int_osc_run,
	output logic o_stop_mode,
	output logic o_main_clk_en,
	output logic o_periph_clk_en,
	output logic o_cpu_clk_en,
	output logic o_low_clk_en
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [SRC_N-1:0] sync1;
		logic [SRC_N-1:0] sync2;
		logic [SRC_N-1:0] prev;
		logic ext_sel;
		logic pin_mode;
		logic gain;
		logic gain_locked;
		logic [7:0] gain_wait;
		logic hs_halt;
		logic src_sel;
		logic mux_bit;
		logic cpu_src;
		logic [2:0] div_code;
		logic [2:0] div_active;
		logic [3:0] div_cnt;
		logic div_pulse;
		logic sub_half;
		logic sub_pulse;
		logic int_halt;
		logic int_stable;
		logic [7:0] settle_cnt;
		logic stop;
		logic cpu_en;
		logic low_en;
		logic [DATA_W-1:0] rdata;
	} hscc_state_t;

	hscc_state_t state;
	hscc_state_t next_state;

	logic [SRC_N-1:0] src_edge;
	logic hs_run;
	logic int_run;
	logic int_pulse;
	logic hs_pulse;
	logic main_pulse;
	logic main_is_hs;
	logic periph_pulse;
	logic cpu_pulse;
	logic cpu_is_sub;

	// ==========================================================
	// helpers

	// last count value of the cpu divider for a ratio code
	function automatic logic [3:0] div_last(input logic [2:0] code);
		logic [3:0] last;
		last = 4'h0;
		case (code)
			3'h0: last = 4'h0;
			3'h1: last = 4'h1;
			3'h2: last = 4'h3;
			3'h3: last = 4'h7;
			3'h4: last = 4'hf;
			default: last = 4'h1;
		endcase
		return last;
	endfunction : div_last

	// register image as software reads it
	function automatic logic [DATA_W-1:0] reg_image(
		input hscc_state_t s,
		input logic [ADDR_W-1:0] addr,
		input logic main_stat,
		input logic sub_stat
	);
		logic [DATA_W-1:0] v;
		v = '0;
		case (addr)
			OFS_OSC_MODE: begin
				v[BIT_EXT_SEL] = s.ext_sel;
				v[BIT_PIN_MODE] = s.pin_mode;
				v[BIT_GAIN] = s.gain;
			end
			OFS_HS_OSC: begin
				v[BIT_HS_HALT] = s.hs_halt;
			end
			OFS_MAIN_MODE: begin
				v[BIT_SRC_SEL] = s.src_sel;
				v[BIT_MAIN_STAT] = main_stat;
				v[BIT_MUX] = s.mux_bit;
			end
			OFS_PROC_CLK: begin
				v[BIT_SUB_STAT] = sub_stat;
				v[BIT_CPU_SRC] = s.cpu_src;
				v[2:0] = s.div_code;
			end
			OFS_INT_OSC: begin
				v[BIT_INT_STABLE] = s.int_stable;
				v[BIT_INT_HALT] = s.int_halt;
			end
			default: v = '0;
		endcase
		return v;
	endfunction : reg_image

	// ==========================================================
	// source sampling and gating

	// a raw oscillator edge is seen only on the second sampler stage
	assign src_edge = state.sync2 & ~state.prev;

	assign hs_run = state.pin_mode & ~state.hs_halt & ~state.stop;
	assign int_run = ~state.int_halt & ~state.stop;
	assign int_pulse = src_edge[SRC_INT] & int_run;
	assign hs_pulse = src_edge[SRC_HS] & hs_run;

	// ==========================================================
	// clock muxes

	hscc_glitchfree_mux u_main_mux (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_pulse_a(int_pulse),
		.i_pulse_b(hs_pulse),
		.i_sel_b(state.src_sel & state.mux_bit),
		.o_pulse(main_pulse),
		.o_sel_b(main_is_hs)
	);

	// peripheral follows source bit
	// peripheral is high-speed whenever main is
	hscc_glitchfree_mux u_periph_mux (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_pulse_a(int_pulse),
		.i_pulse_b(hs_pulse),
		.i_sel_b(state.src_sel),
		.o_pulse(periph_pulse),
		.o_sel_b()
	);

	// cpu picks main or subsystem only
	// the low-speed oscillator has no path into this mux
	hscc_glitchfree_mux u_cpu_mux (
		.i_sys_clk(i_sys_clk),
		.i_reset(i_reset),
		.i_pulse_a(state.div_pulse),
		.i_pulse_b(state.sub_pulse),
		.i_sel_b(state.cpu_src),
		.o_pulse(cpu_pulse),
		.o_sel_b(cpu_is_sub)
	);

	// ==========================================================
	// next state
	always_comb begin
		next_state = state;

		// two-stage samplers for free-running source clocks
		next_state.sync1 = {i_low_osc_clk, i_sub_clk, i_hs_clk,
			i_int_osc_clk};
		next_state.sync2 = state.sync1;
		next_state.prev = state.sync2;

		if (i_stop_exec) begin
			next_state.stop = 1'b1;
		end else if (i_stop_release) begin
			next_state.stop = 1'b0;
		end

		// cpu divider, ratio taken at wrap
		next_state.div_pulse = 1'b0;
		if (main_pulse) begin
			if (state.div_cnt >= div_last(state.div_active)) begin
				next_state.div_cnt = 4'h0;
				next_state.div_pulse = 1'b1;
				next_state.div_active = state.div_code;
			end else begin
				next_state.div_cnt = state.div_cnt + 4'h1;
			end
		end

		// subsystem clock halved for the cpu
		next_state.sub_pulse = 1'b0;
		if (src_edge[SRC_SUB]) begin
			next_state.sub_half = ~state.sub_half;
			next_state.sub_pulse = ~state.sub_half;
		end

		if (state.gain_wait != 8'h00) begin
			next_state.gain_wait = state.gain_wait - 8'h01;
		end
		next_state.cpu_en = cpu_pulse & (state.gain_wait == 8'h00);

		// low-speed clock goes to timers only
		next_state.low_en = src_edge[SRC_LOW];

		if (!int_run) begin
			next_state.int_stable = 1'b0;
			next_state.settle_cnt = 8'h00;
		end else if (int_pulse && !state.int_stable) begin
			if (state.settle_cnt == INT_SETTLE_EDGES - 8'h01) begin
				next_state.int_stable = 1'b1;
			end else begin
				next_state.settle_cnt = state.settle_cnt + 8'h01;
			end
		end

		// register writes
		if (i_wr) begin
			case (i_addr)
				OFS_OSC_MODE: begin
					next_state.ext_sel = i_wdata[BIT_EXT_SEL];
					next_state.pin_mode = i_wdata[BIT_PIN_MODE];
					if (!state.gain_locked &&
						i_wdata[BIT_GAIN] != state.gain) begin
						next_state.gain = i_wdata[BIT_GAIN];
						next_state.gain_locked = 1'b1;
						if (i_wdata[BIT_GAIN]) begin
							next_state.gain_wait = GAIN_HOLD_LOAD;
						end
					end
				end
				OFS_HS_OSC: begin
					next_state.hs_halt = i_wdata[BIT_HS_HALT];
				end
				OFS_MAIN_MODE: begin
					next_state.src_sel = i_wdata[BIT_SRC_SEL];
					next_state.mux_bit = i_wdata[BIT_MUX];
				end
				OFS_PROC_CLK: begin
					next_state.cpu_src = i_wdata[BIT_CPU_SRC];
					if (i_wdata[2:0] <= DIV_CODE_MAX) begin
						next_state.div_code = i_wdata[2:0];
					end
				end
				OFS_INT_OSC: begin
					next_state.int_halt = i_wdata[BIT_INT_HALT];
				end
				default: begin
				end
			endcase
		end

		// status flags from mux state
		// read data stand in the cycle after the strobe only
		if (i_rd) begin
			next_state.rdata = reg_image(state, i_addr, main_is_hs,
				cpu_is_sub);
		end else begin
			next_state.rdata = '0;
		end
	end

	// ==========================================================
	// register the state
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			state <= '0;
			state.pin_mode <= 1'b0;
			state.hs_halt <= RST_HS_HALT;
			state.div_code <= RST_DIV_CODE;
			state.div_active <= RST_DIV_CODE;
			state.int_halt <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// outputs

	assign o_gain_high = state.gain;
	assign o_x1_osc_mode = state.pin_mode & ~state.ext_sel;
	// second pin leaves port mode
	// first pin stays port in external mode
	assign o_x2_clk_mode = state.pin_mode;
	assign o_hs_osc_run = hs_run & ~state.ext_sel;
	assign o_ext_clk_in_en = hs_run & state.ext_sel;
	assign o_int_osc_run = int_run;
	assign o_stop_mode = state.stop;
	assign o_main_clk_en = main_pulse;
	assign o_periph_clk_en = periph_pulse;
	assign o_cpu_clk_en = state.cpu_en;
	assign o_low_clk_en = state.low_en;
	assign o_rdata = state.rdata;

endmodule : hscc_clock_ctrl

//--- bench/hscc_chk.sv
`timescale 1ns/1ps
module hscc_chk
	import hscc_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_stop_exec,
	input wire logic o_gain_high,
	input wire logic o_x1_osc_mode,
	input wire logic o_x2_clk_mode,
	input wire logic o_hs_osc_run,
	input wire logic o_ext_clk_in_en,
	input wire logic o_int_osc_run,
	input wire logic o_stop_mode,
	input wire logic o_cpu_clk_en
);
	// ====
	// hold window after gain rise; two cycles of slack for output pipe
	logic [7:0] hold;
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset)
			hold <= 8'h00;
		else if ($rose(o_gain_high))
			hold <= GAIN_HOLD_LOAD - 8'h02;
		else if (hold != 8'h00)
			hold <= hold - 8'h01;
	end
	// ====
	// stop steps
	sequence s_stop_req;
		i_stop_exec;
	endsequence
	sequence s_hs_quiet;
		o_stop_mode && !o_hs_osc_run && !o_ext_clk_in_en;
	endsequence
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	AST_GAIN_ONCE: assert property ($past(o_gain_high) |-> o_gain_high)
		else $error("gain range changed twice");
	AST_GAIN_HOLD: assert property (hold != 8'h00 |-> !o_cpu_clk_en)
		else $error("cpu clock during gain hold");
	AST_PIN_OSC: assert property (
		i_wr && i_addr == OFS_OSC_MODE |=> o_x1_osc_mode ==
		($past(i_wdata[BIT_PIN_MODE]) && !$past(i_wdata[BIT_EXT_SEL])))
		else $error("first pin mode wrong");
	AST_PIN_EXT: assert property (
		i_wr && i_addr == OFS_OSC_MODE |=>
		o_x2_clk_mode == $past(i_wdata[BIT_PIN_MODE]))
		else $error("second pin mode wrong");
	AST_HS_START: assert property (
		i_wr && i_addr == OFS_HS_OSC && !i_wdata[BIT_HS_HALT] &&
		o_x1_osc_mode && !o_stop_mode && !i_stop_exec |=> o_hs_osc_run)
		else $error("oscillator did not start");
	AST_HS_HALT: assert property (
		i_wr && i_addr == OFS_HS_OSC && i_wdata[BIT_HS_HALT] |=>
		!o_hs_osc_run && !o_ext_clk_in_en)
		else $error("high-speed source not halted");
	AST_STOP: assert property (s_stop_req |=> s_hs_quiet)
		else $error("stop left high-speed source on");
	AST_INT_RESTART: assert property (
		i_wr && i_addr == OFS_INT_OSC && !i_wdata[BIT_INT_HALT] &&
		!o_stop_mode && !i_stop_exec |=> o_int_osc_run)
		else $error("internal oscillator not restarted");
	AST_INT_BOOT: assert property ($past(i_reset) |-> o_int_osc_run)
		else $error("internal oscillator off after reset");
	AST_CPU_PULSE: assert property (
		o_cpu_clk_en |=> !o_cpu_clk_en [*2])
		else $error("cpu enable pulses too close");
endmodule : hscc_chk

bind hscc_clock_ctrl hscc_chk chk_u (
	.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_stop_exec(i_stop_exec),
	.o_gain_high(o_gain_high), .o_x1_osc_mode(o_x1_osc_mode),
	.o_x2_clk_mode(o_x2_clk_mode), .o_hs_osc_run(o_hs_osc_run),
	.o_ext_clk_in_en(o_ext_clk_in_en), .o_int_osc_run(o_int_osc_run),
	.o_stop_mode(o_stop_mode), .o_cpu_clk_en(o_cpu_clk_en)
);

//--- bench/hscc_src_model.sv
`timescale 1ns/1ps
module hscc_src_model (
	input wire logic i_hs_en,
	input wire logic i_int_en,
	output logic o_hs_clk,
	output logic o_int_clk,
	output logic o_sub_clk,
	output logic o_low_clk
);
	// ====
	// source clocks, phases unrelated to the system clock
	initial begin
		o_hs_clk = 1'b0;
		o_int_clk = 1'b0;
		o_sub_clk = 1'b0;
		o_low_clk = 1'b0;
		#7;
	end
	always begin
		#93 o_hs_clk = i_hs_en ? ~o_hs_clk : 1'b0;
	end
	always begin
		#101 o_int_clk = i_int_en ? ~o_int_clk : 1'b0;
	end
	// free running, not under this block's control
	always #151 o_sub_clk = ~o_sub_clk;
	always #503 o_low_clk = ~o_low_clk;
endmodule : hscc_src_model

//--- bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
	error_cnt++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top
	import hscc_pkg::*;
;
	// ====
	// signals
	logic i_sys_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic i_stop_exec = 1'b0, i_stop_release = 1'b0, rd_q = 1'b0;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wdata = '0, o_rdata, we, wm;
	logic o_gain_high, o_x1_osc_mode, o_x2_clk_mode, o_hs_osc_run;
	logic o_ext_clk_in_en, o_int_osc_run, o_stop_mode, o_main_clk_en;
	logic o_periph_clk_en, o_cpu_clk_en, o_low_clk_en;
	logic hs_clk, int_clk, sub_clk, low_clk;
	logic [31:0] lfsr = 32'hbb33_1522;
	logic [DATA_W-1:0] exp_q[$], msk_q[$];
	int error_cnt = 0, checked = 0;
	always #10 i_sys_clk = ~i_sys_clk;
	hscc_clock_ctrl dut_u (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_int_osc_clk(int_clk), .i_hs_clk(hs_clk),
		.i_sub_clk(sub_clk), .i_low_osc_clk(low_clk),
		.i_stop_exec(i_stop_exec), .i_stop_release(i_stop_release),
		.o_gain_high(o_gain_high), .o_x1_osc_mode(o_x1_osc_mode),
		.o_x2_clk_mode(o_x2_clk_mode), .o_hs_osc_run(o_hs_osc_run),
		.o_ext_clk_in_en(o_ext_clk_in_en), .o_int_osc_run(o_int_osc_run),
		.o_stop_mode(o_stop_mode), .o_main_clk_en(o_main_clk_en),
		.o_periph_clk_en(o_periph_clk_en), .o_cpu_clk_en(o_cpu_clk_en),
		.o_low_clk_en(o_low_clk_en));
	hscc_src_model src_u (.i_hs_en(o_hs_osc_run | o_ext_clk_in_en),
		.i_int_en(o_int_osc_run), .o_hs_clk(hs_clk), .o_int_clk(int_clk),
		.o_sub_clk(sub_clk), .o_low_clk(low_clk));
	// ====
	// helpers
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	task automatic summarize();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
	endtask : wr
	// expectation noted when the strobe goes out
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, m);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
	endtask : cyc
	task automatic poll(input logic [ADDR_W-1:0] a, input int b);
		int k;
		for (k = 0; k < 200; k++) begin
			rd(a, 8'h00, 8'h00);
			@(negedge i_sys_clk);
			if (o_rdata[b] === 1'b1)
				break;
		end
		`CHK("poll", 1'b1, o_rdata[b])
		if (k == 200)
			summarize();
	endtask : poll
	task automatic cnt(input int n, output int m, c, p, l);
		m = 0;
		c = 0;
		p = 0;
		l = 0;
		repeat (n) begin
			@(negedge i_sys_clk);
			m += (o_main_clk_en === 1'b1);
			c += (o_cpu_clk_en === 1'b1);
			p += (o_periph_clk_en === 1'b1);
			l += (o_low_clk_en === 1'b1);
		end
	endtask : cnt
	// read data sampled mid-cycle, well clear of the edge
	always @(posedge i_sys_clk) rd_q <= i_rd;
	always @(negedge i_sys_clk) begin
		if (rd_q === 1'b1 && exp_q.size() > 0) begin
			we = exp_q.pop_front();
			wm = msk_q.pop_front();
			`CHK("rdata", we, o_rdata & wm)
		end
	end
	initial begin
		#2_000_000;
		error_cnt++;
		summarize();
	end
	// ====
	// main sequence
	initial begin
		int m, c, p, k, d, l;
		repeat (12) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		rd(OFS_OSC_MODE, 8'h00, 8'hff);
		rd(OFS_HS_OSC, 8'h80, 8'hff);
		rd(OFS_MAIN_MODE, 8'h00, 8'hff);
		rd(OFS_PROC_CLK, 8'h01, 8'hff);
		rd(OFS_INT_OSC, 8'h00, 8'hff);
		wr(3'h6, lfsr[7:0]);
		rd(3'h6, 8'h00, 8'hff);
		cyc(1);
		`CHK("x1", 1'b0, o_x1_osc_mode)
		`CHK("x2", 1'b0, o_x2_clk_mode)
		`CHK("int_run", 1'b1, o_int_osc_run)
		poll(OFS_INT_OSC, BIT_INT_STABLE);
		wr(OFS_OSC_MODE, 8'h01);
		// withhold begins after the write edge; that edge may still pulse
		@(posedge i_sys_clk);
		cnt(200, m, c, p, l);
		`CHK("gain", 1'b1, o_gain_high)
		`CHK("hold", 0, c)
		wr(OFS_OSC_MODE, 8'h00);
		rd(OFS_OSC_MODE, 8'h01, 8'hff);
		wr(OFS_OSC_MODE, 8'h41);
		wr(OFS_HS_OSC, 8'h00);
		cyc(1);
		`CHK("x1", 1'b1, o_x1_osc_mode)
		`CHK("x2", 1'b1, o_x2_clk_mode)
		`CHK("hs_run", 1'b1, o_hs_osc_run)
		`CHK("ext", 1'b0, o_ext_clk_in_en)
		// model source is settled from its first edge
		wr(OFS_MAIN_MODE, 8'h05);
		cyc(60);
		rd(OFS_MAIN_MODE, 8'h07, 8'hff);
		for (k = 0; k < 5; k++) begin
			wr(OFS_PROC_CLK, 8'(k));
			cyc(40);
			cnt(930, m, c, p, l);
			d = (c << k) - m;
			`CHK("low", 1'b1, l >= 17 && l <= 20)
			`CHK("main_hs", 1'b1, m >= 97 && m <= 103)
			`CHK("periph", m, p)
			`CHK("div", 1'b1, d <= (1 << k) + 2 && d >= -(1 << k) - 2)
		end
		lfsr = nxt(lfsr);
		wr(OFS_PROC_CLK, 8'(5 + lfsr % 3));
		rd(OFS_PROC_CLK, 8'h04, 8'hff);
		wr(OFS_MAIN_MODE, 8'h00);
		cyc(60);
		rd(OFS_MAIN_MODE, 8'h00, 8'hff);
		wr(OFS_HS_OSC, 8'h80);
		cyc(1);
		`CHK("hs_run", 1'b0, o_hs_osc_run)
		wr(OFS_OSC_MODE, 8'hc1);
		wr(OFS_HS_OSC, 8'h00);
		cyc(1);
		`CHK("x1", 1'b0, o_x1_osc_mode)
		`CHK("x2", 1'b1, o_x2_clk_mode)
		`CHK("ext", 1'b1, o_ext_clk_in_en)
		`CHK("hs_run", 1'b0, o_hs_osc_run)
		@(posedge i_sys_clk);
		i_stop_exec <= 1'b1;
		@(posedge i_sys_clk);
		i_stop_exec <= 1'b0;
		cyc(1);
		`CHK("stop", 1'b1, o_stop_mode)
		`CHK("ext", 1'b0, o_ext_clk_in_en)
		@(posedge i_sys_clk);
		i_stop_release <= 1'b1;
		@(posedge i_sys_clk);
		i_stop_release <= 1'b0;
		cyc(1);
		`CHK("ext", 1'b1, o_ext_clk_in_en)
		wr(OFS_PROC_CLK, 8'h10);
		// old divider may still run /16 until its wrap hands over
		cyc(250);
		rd(OFS_PROC_CLK, 8'h30, 8'hff);
		wr(OFS_INT_OSC, 8'h01);
		cnt(900, m, c, p, l);
		`CHK("int_run", 1'b0, o_int_osc_run)
		`CHK("cpu_sub", 1'b1, c >= 28 && c <= 32)
		wr(OFS_INT_OSC, 8'h00);
		cyc(1);
		`CHK("int_run", 1'b1, o_int_osc_run)
		poll(OFS_INT_OSC, BIT_INT_STABLE);
		summarize();
	end
endmodule : tb_top
